// ---- cod_regs.svh ----
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

// ********************************************
// opcode bytes
// ********************************************
`define COD_OP_ESC      8'h0f
`define COD_OP_STD      8'hfd
`define COD_OP_STI      8'hfb
`define COD_OP_WAIT     8'h9b
`define COD_OP2_SAVE_SEGMENT_DESCRIPTOR_OP    8'h78
`define COD_OP2_SAVE_LOCAL_TABLE_OP   8'h7a
`define COD_OP2_SAVE_TASK_REGISTER_OP    8'h7c
`define COD_OP2_GRP0    8'h00
`define COD_OP2_FLUSH_AND_INVALIDATE_OP  8'h09
`define COD_OP2_EXCHANGE_SUM_OP    7'h60
`define COD_REG_CHECK_READ_ACCESS_OP    3'h4
`define COD_REG_CHECK_WRITE_ACCESS_OP    3'h5
`define COD_REG_IMM_SUB 3'h5
`define COD_REG_IMM_XOR 3'h6
`define COD_REG_TEST    3'h0

// ********************************************
// clock counts on a cache hit
// ********************************************
`define COD_CLK_STD     17'h00004
`define COD_CLK_STI     17'h00006
`define COD_CLK_ALU     17'h00001
`define COD_CLK_SAVE_SEGMENT_DESCRIPTOR_OP    17'h00014
`define COD_CLK_SAVE_LOCAL_TABLE_OP   17'h00014
`define COD_CLK_SAVE_TASK_REGISTER_OP    17'h00015
`define COD_CLK_VER     17'h00008
`define COD_CLK_WAIT    17'h00001
`define COD_CLK_FLUSH_AND_INVALIDATE_OP  17'h00017
`define COD_CLK_EXCHANGE_SUM_OP    17'h00002
`define COD_CLK_SWAP_OP    17'h00002

// ********************************************
// exception vectors and limits
// ********************************************
`define COD_VEC_UD      8'h06
`define COD_VEC_SS      8'h0c
`define COD_VEC_GP      8'h0d
`define COD_REAL_LIMIT  33'h00000ffff

// ********************************************
// flag positions in the flag bus
// ********************************************
`define COD_F_CF        0
`define COD_F_PF        1
`define COD_F_AF        2
`define COD_F_ZF        3
`define COD_F_SF        4
`define COD_F_OF        5
`define COD_F_DF        6
`define COD_F_IF        7

`endif

// ---- cod_pkg.sv ----
package cod_pkg;

    // instruction classes handled here
    typedef enum logic [3:0] {
        COD_K_PASS, COD_K_STD, COD_K_STI, COD_K_SUB, COD_K_SAVE_SEGMENT_DESCRIPTOR_OP, COD_K_SAVE_LOCAL_TABLE_OP,
        COD_K_SAVE_TASK_REGISTER_OP, COD_K_TEST, COD_K_CHECK_READ_ACCESS_OP, COD_K_CHECK_WRITE_ACCESS_OP, COD_K_WAIT,
        COD_K_FLUSH_AND_INVALIDATE_OP, COD_K_EXCHANGE_SUM_OP, COD_K_SWAP_OP, COD_K_XOR
    } cod_kind_e;

    // arithmetic flavour for the flag unit
    typedef enum logic [1:0] {
        COD_ALU_SUB, COD_ALU_ADD, COD_ALU_LOGIC_AND, COD_ALU_LOGIC_XOR
    } cod_alu_e;

    typedef enum logic [1:0] {
        COD_ST_IDLE, COD_ST_EXEC, COD_ST_FPU
    } cod_state_e;

    // even parity of the low byte, as the parity flag wants
    function automatic logic cod_parity(input logic [7:0] v);
        cod_parity = ~^v;
    endfunction : cod_parity

endpackage : cod_pkg

// ---- cod_flag_unit.sv ----
`timescale 1ns/1ps
`include "cod_regs.svh"

module cod_flag_unit
    import cod_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         start_in,
    input  wire cod_alu_e     alu_in,
    input  wire logic [W-1:0] a_in,
    input  wire logic [W-1:0] b_in,
    output logic      [W-1:0] result_out,
    output logic      [7:0]   flags_out
);

    typedef struct packed {
        logic [W-1:0] res;
        logic [7:0]   fl;
    } cod_fu_s;

    cod_fu_s cur;
    cod_fu_s next_cur;

    // ********************************************
    // result and six arithmetic flags
    // ********************************************
    // one adder serves both add and subtract to keep the unit small
    always_comb begin
        logic [W:0]   sum;
        logic [W-1:0] bb;
        logic [W-1:0] r;
        logic         sub;
        sum = '0;
        bb = '0;
        r = '0;
        sub = 1'b0;
        next_cur = cur;
        if (start_in) begin
            sub = (alu_in == COD_ALU_SUB);
            bb = sub ? ~b_in : b_in;
            sum = {1'b0, a_in} + {1'b0, bb} + {{W{1'b0}}, sub};
            case (alu_in)
                COD_ALU_SUB, COD_ALU_ADD: r = sum[W-1:0];
                COD_ALU_LOGIC_AND:        r = a_in & b_in;
                default:                  r = a_in ^ b_in;
            endcase
            next_cur.res = r;
            next_cur.fl = '0;
            next_cur.fl[`COD_F_ZF] = (r == '0);
            next_cur.fl[`COD_F_SF] = r[W-1];
            next_cur.fl[`COD_F_PF] = cod_parity(r[7:0]);
            if (alu_in == COD_ALU_SUB || alu_in == COD_ALU_ADD) begin
                // borrow is the inverted carry on subtract
                next_cur.fl[`COD_F_CF] = sum[W] ^ sub;
                next_cur.fl[`COD_F_AF] = a_in[4] ^ b_in[4] ^ r[4];
                next_cur.fl[`COD_F_OF] = (a_in[W-1] == bb[W-1]) && (r[W-1] != a_in[W-1]);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign result_out = cur.res;
    assign flags_out  = cur.fl;

endmodule : cod_flag_unit

// ---- cod_decode_tail.sv ----
`timescale 1ns/1ps
`include "cod_regs.svh"

// How it works
// - set-direction sets DF only, 4 clocks
// - set-interrupt sets IF, 6 clocks, IOPL checked outside real mode
// - subtract forms other than 82 /5: six flags, 1 clock
// - segment descriptor save: 20 clocks, no flags
// - local table save: 20 clocks, no flags
// - task register save: 21 clocks, no flags
// - bit test clears OF, CF; 1 clock
// - read access check: ZF only, 8 clocks
// - write access check: ZF only, 8 clocks
// - wait stalls until FPU idle, 1 clock base
// - cache flush: 23 clocks, no flags
// - exchange-sum swaps, adds, sets flags, 2 clocks
// - exclusive or clears OF, CF; 1 clock
// - protected-only ops in real mode raise 6
// - real mode past FFFFH raises 13
// - real mode stack overrun raises 12
// - register-memory swap asserts bus lock
// - mgmt saves uncached, gated else vector 6
// - write-back cache adds dirty-line clocks

module cod_decode_tail
    import cod_pkg::*;
#(
    parameter int W = 32,
    parameter int DW = 16
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          instr_valid_in,
    input  wire logic [7:0]    op0_in,
    input  wire logic [7:0]    op1_in,
    input  wire logic [7:0]    modrm_in,
    input  wire logic          real_mode_in,
    input  wire logic [W-1:0]  operand_a_in,
    input  wire logic [W-1:0]  operand_b_in,
    input  wire logic [31:0]   ea_offset_in,
    input  wire logic [2:0]    access_size_in,
    input  wire logic          ea_stack_in,
    input  wire logic          selector_ok_in,
    input  wire logic [1:0]    current_privilege_level_in,
    input  wire logic [1:0]    iopl_in,
    input  wire logic          fpu_busy_in,
    input  wire logic          cache_wb_mode_in,
    input  wire logic [DW-1:0] dirty_lines_in,
    input  wire logic          smi_enable_in,
    input  wire logic [31:0]   mgmt_region_size_in,
    input  wire logic          smm_access_in,
    input  wire logic          smi_handler_in,
    output logic               busy_out,
    output logic               done_out,
    output logic [7:0]         flags_out,
    output logic [7:0]         flags_we_out,
    output logic [W-1:0]       result_out,
    output logic [W-1:0]       swap_out,
    output logic               exc_valid_out,
    output logic [7:0]         exc_vector_out,
    output logic               lock_out,
    output logic               noncache_out,
    output logic               cache_flush_out,
    output logic               pass_valid_out,
    output logic [7:0]         pass_op0_out,
    output logic [7:0]         pass_op1_out,
    output logic [7:0]         pass_modrm_out
);

    typedef struct packed {
        cod_state_e  st;
        logic        bsy;
        cod_kind_e   kind;
        logic [16:0] cnt;
        logic        zf_ok;
        logic        done;
        logic [7:0]  flags;
        logic [7:0]  we;
        logic [W-1:0] res;
        logic [W-1:0] swp;
        logic        exc;
        logic [7:0]  vec;
        logic        lock;
        logic        nc;
        logic        flush;
        logic        pv;
        logic [7:0]  p0;
        logic [7:0]  p1;
        logic [7:0]  pm;
    } cod_st_s;

    cod_st_s     cur;
    cod_st_s     next_cur;
    cod_kind_e   dk;
    logic        dmem;
    cod_alu_e    dalu;
    logic [W-1:0] fu_res;
    logic [7:0]  fu_fl;

    // ********************************************
    // opcode classification
    // ********************************************
    function automatic cod_kind_e cod_decode(input logic [7:0] b0, input logic [7:0] b1,
                                             input logic [7:0] m);
        cod_kind_e k;
        k = COD_K_PASS;
        if (b0 == `COD_OP_ESC) begin
            if (b1 == `COD_OP2_SAVE_SEGMENT_DESCRIPTOR_OP) k = COD_K_SAVE_SEGMENT_DESCRIPTOR_OP;
            else if (b1 == `COD_OP2_SAVE_LOCAL_TABLE_OP) k = COD_K_SAVE_LOCAL_TABLE_OP;
            else if (b1 == `COD_OP2_SAVE_TASK_REGISTER_OP) k = COD_K_SAVE_TASK_REGISTER_OP;
            else if (b1 == `COD_OP2_FLUSH_AND_INVALIDATE_OP) k = COD_K_FLUSH_AND_INVALIDATE_OP;
            else if (b1[7:1] == `COD_OP2_EXCHANGE_SUM_OP) k = COD_K_EXCHANGE_SUM_OP;
            else if (b1 == `COD_OP2_GRP0 && m[5:3] == `COD_REG_CHECK_READ_ACCESS_OP) k = COD_K_CHECK_READ_ACCESS_OP;
            else if (b1 == `COD_OP2_GRP0 && m[5:3] == `COD_REG_CHECK_WRITE_ACCESS_OP) k = COD_K_CHECK_WRITE_ACCESS_OP;
        end else if (b0 == `COD_OP_STD) k = COD_K_STD;
        else if (b0 == `COD_OP_STI) k = COD_K_STI;
        else if (b0 == `COD_OP_WAIT) k = COD_K_WAIT;
        else if (b0 >= 8'h28 && b0 <= 8'h2d) k = COD_K_SUB;
        else if (b0 >= 8'h30 && b0 <= 8'h35) k = COD_K_XOR;
        else if (b0 == 8'h84 || b0 == 8'h85 || b0 == 8'ha8 || b0 == 8'ha9) k = COD_K_TEST;
        else if ((b0 == 8'hf6 || b0 == 8'hf7) && m[5:3] == `COD_REG_TEST) k = COD_K_TEST;
        else if (b0 == 8'h86 || b0 == 8'h87 || b0[7:3] == 5'h12) k = COD_K_SWAP_OP;
        else if (b0[7:2] == 6'h20 && b0 != 8'h82 && m[5:3] == `COD_REG_IMM_SUB) k = COD_K_SUB;
        else if (b0[7:2] == 6'h20 && b0 != 8'h82 && m[5:3] == `COD_REG_IMM_XOR) k = COD_K_XOR;
        cod_decode = k;
    endfunction : cod_decode

    // the mod field says memory unless it is 11; short forms carry none
    function automatic logic cod_has_mem(input logic [7:0] b0, input logic [7:0] m);
        logic modrm;
        modrm = !(b0 == 8'h2c || b0 == 8'h2d || b0 == 8'h34 || b0 == 8'h35 ||
                  b0 == 8'ha8 || b0 == 8'ha9 || b0[7:3] == 5'h12 ||
                  b0 == `COD_OP_STD || b0 == `COD_OP_STI || b0 == `COD_OP_WAIT);
        cod_has_mem = modrm && (m[7:6] != 2'b11) &&
                      !(b0 == `COD_OP_ESC && m == 8'h00 && 1'b0);
    endfunction : cod_has_mem

    assign dk   = cod_decode(op0_in, op1_in, modrm_in);
    assign dmem = cod_has_mem(op0_in, modrm_in) && dk != COD_K_FLUSH_AND_INVALIDATE_OP;
    assign dalu = (dk == COD_K_SUB)  ? COD_ALU_SUB :
                  (dk == COD_K_EXCHANGE_SUM_OP) ? COD_ALU_ADD :
                  (dk == COD_K_TEST) ? COD_ALU_LOGIC_AND : COD_ALU_LOGIC_XOR;

    // flag unit registers alongside the take edge, ready one cycle later
    cod_flag_unit #(
        .W (W)
    ) u_flags (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .start_in   (cur.st == COD_ST_IDLE && instr_valid_in),
        .alu_in     (dalu),
        .a_in       (operand_a_in),
        .b_in       (operand_b_in),
        .result_out (fu_res),
        .flags_out  (fu_fl)
    );

    // ********************************************
    // sequencer
    // ********************************************
    always_comb begin
        logic [32:0] last;
        logic        smm_ok;
        logic [16:0] n;
        last = {1'b0, ea_offset_in} + {30'h0, access_size_in} - 33'h1;
        smm_ok = smi_enable_in && (mgmt_region_size_in != 32'h0) &&
                 (current_privilege_level_in == 2'h0) && (smm_access_in || smi_handler_in);
        n = 17'h0;
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.exc = 1'b0;
        next_cur.pv = 1'b0;
        next_cur.flush = 1'b0;
        case (cur.st)
            COD_ST_IDLE: begin
                if (instr_valid_in) begin
                    next_cur.kind = dk;
                    next_cur.zf_ok = selector_ok_in;
                    next_cur.we = 8'h00;
                    next_cur.vec = 8'h00;
                    case (dk)
                        COD_K_STD:    n = `COD_CLK_STD;
                        COD_K_STI:    n = `COD_CLK_STI;
                        COD_K_SUB, COD_K_TEST, COD_K_XOR: n = `COD_CLK_ALU;
                        COD_K_SAVE_SEGMENT_DESCRIPTOR_OP:   n = `COD_CLK_SAVE_SEGMENT_DESCRIPTOR_OP;
                        COD_K_SAVE_LOCAL_TABLE_OP:  n = `COD_CLK_SAVE_LOCAL_TABLE_OP;
                        COD_K_SAVE_TASK_REGISTER_OP:   n = `COD_CLK_SAVE_TASK_REGISTER_OP;
                        COD_K_CHECK_READ_ACCESS_OP, COD_K_CHECK_WRITE_ACCESS_OP: n = `COD_CLK_VER;
                        COD_K_WAIT:   n = `COD_CLK_WAIT;
                        COD_K_FLUSH_AND_INVALIDATE_OP: n = `COD_CLK_FLUSH_AND_INVALIDATE_OP +
                                          (cache_wb_mode_in ? 17'(dirty_lines_in) : 17'h0);
                        COD_K_EXCHANGE_SUM_OP:   n = `COD_CLK_EXCHANGE_SUM_OP;
                        COD_K_SWAP_OP:   n = `COD_CLK_SWAP_OP;
                        default:      n = 17'h0;
                    endcase
                    if (dk == COD_K_PASS) begin
                        next_cur.pv = 1'b1;
                        next_cur.p0 = op0_in;
                        next_cur.p1 = op1_in;
                        next_cur.pm = modrm_in;
                    end else if (real_mode_in && (dk == COD_K_CHECK_READ_ACCESS_OP || dk == COD_K_CHECK_WRITE_ACCESS_OP)) begin
                        next_cur.exc = 1'b1;
                        next_cur.vec = `COD_VEC_UD;
                    end else if ((dk == COD_K_SAVE_SEGMENT_DESCRIPTOR_OP || dk == COD_K_SAVE_LOCAL_TABLE_OP || dk == COD_K_SAVE_TASK_REGISTER_OP)
                                 && !smm_ok) begin
                        next_cur.exc = 1'b1;
                        next_cur.vec = `COD_VEC_UD;
                    end else if (real_mode_in && dmem && last > `COD_REAL_LIMIT) begin
                        next_cur.exc = 1'b1;
                        next_cur.vec = ea_stack_in ? `COD_VEC_SS : `COD_VEC_GP;
                    end else if (dk == COD_K_STI && !real_mode_in &&
                                 current_privilege_level_in > iopl_in) begin
                        next_cur.exc = 1'b1;
                        next_cur.vec = `COD_VEC_GP;
                    end else begin
                        next_cur.st = COD_ST_EXEC;
                        next_cur.cnt = n - 17'h1;
                        next_cur.lock = (dk == COD_K_SWAP_OP) && dmem;
                        next_cur.nc = (dk == COD_K_SAVE_SEGMENT_DESCRIPTOR_OP || dk == COD_K_SAVE_LOCAL_TABLE_OP ||
                                       dk == COD_K_SAVE_TASK_REGISTER_OP);
                        next_cur.flush = (dk == COD_K_FLUSH_AND_INVALIDATE_OP);
                        next_cur.swp = operand_a_in;
                    end
                end
            end
            COD_ST_EXEC: begin
                if (cur.cnt != 17'h0) begin
                    next_cur.cnt = cur.cnt - 17'h1;
                end else if (cur.kind == COD_K_WAIT && fpu_busy_in) begin
                    next_cur.st = COD_ST_FPU;
                end else begin
                    next_cur.st = COD_ST_IDLE;
                    next_cur.done = 1'b1;
                    next_cur.lock = 1'b0;
                    next_cur.nc = 1'b0;
                    next_cur.res = fu_res;
                    next_cur.flags = 8'h00;
                    next_cur.we = 8'h00;
                    case (cur.kind)
                        COD_K_STD: begin
                            next_cur.flags[`COD_F_DF] = 1'b1;
                            next_cur.we[`COD_F_DF] = 1'b1;
                        end
                        COD_K_STI: begin
                            next_cur.flags[`COD_F_IF] = 1'b1;
                            next_cur.we[`COD_F_IF] = 1'b1;
                        end
                        COD_K_SUB, COD_K_EXCHANGE_SUM_OP: begin
                            next_cur.flags = fu_fl;
                            next_cur.we = 8'h3f;
                        end
                        COD_K_TEST, COD_K_XOR: begin
                            next_cur.flags = fu_fl;
                            next_cur.we = 8'h3b;
                        end
                        COD_K_CHECK_READ_ACCESS_OP, COD_K_CHECK_WRITE_ACCESS_OP: begin
                            next_cur.flags[`COD_F_ZF] = cur.zf_ok;
                            next_cur.we[`COD_F_ZF] = 1'b1;
                        end
                        default: next_cur.we = 8'h00;
                    endcase
                end
            end
            COD_ST_FPU: begin
                if (!fpu_busy_in) begin
                    next_cur.st = COD_ST_IDLE;
                    next_cur.done = 1'b1;
                    next_cur.we = 8'h00;
                end
            end
            default: next_cur.st = COD_ST_IDLE;
        endcase
        // busy kept as its own flop so the pin carries no decode
        next_cur.bsy = (next_cur.st != COD_ST_IDLE);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ********************************************
    // outputs, all from the state register
    // ********************************************
    assign busy_out        = cur.bsy;
    assign done_out        = cur.done;
    assign flags_out       = cur.flags;
    assign flags_we_out    = cur.we;
    assign result_out      = cur.res;
    assign swap_out        = cur.swp;
    assign exc_valid_out   = cur.exc;
    assign exc_vector_out  = cur.vec;
    assign lock_out        = cur.lock;
    assign noncache_out    = cur.nc;
    assign cache_flush_out = cur.flush;
    assign pass_valid_out  = cur.pv;
    assign pass_op0_out    = cur.p0;
    assign pass_op1_out    = cur.p1;
    assign pass_modrm_out  = cur.pm;

    // ********************************************
    // checks
    // ********************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic take;
    assign take = (cur.st == COD_ST_IDLE) && instr_valid_in && dk != COD_K_PASS;

    a_std_four: assert property (take && dk == COD_K_STD && !real_mode_in ##1 !cur.exc
        |-> ##4 done_out && flags_we_out == 8'h40) else $error("std timing");
    a_sti_six: assert property (take && dk == COD_K_STI ##1 !cur.exc
        |-> ##6 done_out && flags_we_out == 8'h80) else $error("sti timing");
    a_sub_one: assert property (take && dk == COD_K_SUB && !dmem
        |=> ##1 done_out && flags_we_out == 8'h3f) else $error("sub timing");
    a_save_task_register_op_21: assert property (take && dk == COD_K_SAVE_TASK_REGISTER_OP ##1 !cur.exc
        |-> ##20 !done_out ##1 done_out && flags_we_out == 8'h00)
        else $error("save_task_register_op timing");
    a_xor_flags: assert property (take && dk == COD_K_XOR && !dmem
        |=> ##1 flags_we_out == 8'h3b && !flags_out[`COD_F_CF] && !flags_out[`COD_F_OF])
        else $error("xor flags");
    a_ver_real: assert property (take && (dk == COD_K_CHECK_READ_ACCESS_OP || dk == COD_K_CHECK_WRITE_ACCESS_OP) && real_mode_in
        |=> exc_valid_out && exc_vector_out == `COD_VEC_UD && !busy_out)
        else $error("ver real");
    a_wait_fpu: assert property (cur.st == COD_ST_FPU && fpu_busy_in |=> !done_out)
        else $error("wait early");
    a_swap_lock: assert property (take && dk == COD_K_SWAP_OP && dmem ##1 busy_out
        |-> lock_out ##1 lock_out ##1 !lock_out) else $error("swap lock");
    a_pass_thru: assert property ((cur.st == COD_ST_IDLE) && instr_valid_in && dk == COD_K_PASS
        |=> pass_valid_out && pass_op0_out == $past(op0_in) && !busy_out)
        else $error("pass");

    c_sub: cover property (take && dk == COD_K_SUB ##1 done_out);
    c_gp: cover property (exc_valid_out && exc_vector_out == `COD_VEC_GP);
    c_fpu: cover property (cur.st == COD_ST_FPU ##1 done_out);
    c_flush: cover property (cache_flush_out);

endmodule : cod_decode_tail

// ---- cod_fpu_model.sv ----
`timescale 1ns/1ps
module cod_fpu_model (
    input  wire logic       sys_clk_in,
    input  wire logic [3:0] hold_in,
    output logic            fpu_busy_out
);
    logic [3:0] left = 4'h0;

    // busy for a commanded number of cycles; never idles early
    always_ff @(posedge sys_clk_in) begin
        if (hold_in != 4'h0) begin
            left <= hold_in;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    assign fpu_busy_out = (left != 4'h0);
endmodule : cod_fpu_model

// ---- core_opcode_decode_tail_test.sv ----
`timescale 1ns/1ps
module core_opcode_decode_tail_test;
    import cod_pkg::*;
    // ********************************************
    // stimulus and observed signals
    // ********************************************
    logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, real_m = 1'b0;
    logic        stk = 1'b0, wb = 1'b0, smi = 1'b1;
    logic [7:0]  o0 = 8'h00, o1 = 8'h00, m = 8'h00;
    logic [31:0] a = 32'h0, b = 32'h0, ea = 32'h0, x;
    logic [2:0]  sz = 3'h1;
    logic [15:0] dirty = 16'h0;
    logic [3:0]  hold = 4'h0;
    logic        fpu, busy, done, exc, lock, nc, flush, pv, lk, ncs;
    logic [7:0]  fl, we, vec, p0;
    logic [31:0] res, swp;
    logic        fs;
    logic [32:0] w;
    int          mismatches = 0, num_checks = 0, k;
    // one row per opcode form: op0 op1 modrm clocks write-mask
    logic [39:0] tab [20] = '{40'hfd00c00440, 40'hfb00c00680, 40'h2900c0013f, 40'h2d0000013f,
        40'h8100e8013f, 40'h0f78c01400, 40'h0f7ac01400, 40'h0f7cc01500, 40'h8500c0013b,
        40'hf700c0013b, 40'h0f00e00808, 40'h0f00e80808, 40'h9b00000100, 40'h0f09c01700,
        40'h0fc1c0023f, 40'h8700c00200, 40'h9100000200, 40'h3100c0013b, 40'h350000013b,
        40'h8100f0013b};

    cod_fpu_model i_fpu (.sys_clk_in(clk), .hold_in(hold), .fpu_busy_out(fpu));
    // privilege and mgmt-region inputs tied to the permissive case
    cod_decode_tail i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .instr_valid_in(vld),
        .op0_in(o0), .op1_in(o1), .modrm_in(m), .real_mode_in(real_m), .operand_a_in(a),
        .operand_b_in(b), .ea_offset_in(ea), .access_size_in(sz), .ea_stack_in(stk),
        .selector_ok_in(a[0]), .current_privilege_level_in(2'h0), .iopl_in(2'h0),
        .fpu_busy_in(fpu), .cache_wb_mode_in(wb), .dirty_lines_in(dirty), .smi_enable_in(smi),
        .mgmt_region_size_in(32'h1), .smm_access_in(1'b1), .smi_handler_in(1'b0),
        .busy_out(busy), .done_out(done), .flags_out(fl), .flags_we_out(we), .result_out(res),
        .swap_out(swp), .exc_valid_out(exc), .exc_vector_out(vec), .lock_out(lock),
        .noncache_out(nc), .cache_flush_out(flush), .pass_valid_out(pv), .pass_op0_out(p0),
        .pass_op1_out(), .pass_modrm_out());

    // free-running core clock
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // offer one instruction, return just after its take edge
    task automatic take(input logic [23:0] ins);
        @(posedge clk);
        {o0, o1, m} <= ins;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask : take

    // bounded wait for done; a zero clock field skips the exact count
    task automatic run(input logic [39:0] row);
        take(row[39:16]);
        k = 0;
        lk = 1'b0;
        ncs = 1'b0;
        fs = 1'b0;
        while (done !== 1'b1 && k < 80) begin
            lk |= lock;
            fs |= flush;
            ncs |= nc;
            @(posedge clk);
            #1;
            k++;
        end
        if (row[15:8] != 8'h0) check(k, row[15:8]);
        check(we, row[7:0]);
        $display("test %h done", row[39:16]);
    endtask : run

    task automatic fault(input logic [23:0] ins, input logic [7:0] v);
        take(ins);
        check(exc, 1);
        check(vec, v);
        $display("test %h done", ins);
    endtask : fault

    // expected result for the subtract and exclusive-or forms only
    function automatic logic [32:0] want(input logic [7:0] op, input logic [7:0] md);
        if (op == 8'h29 || op == 8'h2d || (op == 8'h81 && md[5:3] == 3'h5)) return {1'b1, a - b};
        if (op == 8'h31 || op == 8'h35 || (op == 8'h81 && md[5:3] == 3'h6)) return {1'b1, a ^ b};
        return 33'h0;
    endfunction : want

    // ********************************************
    // tests
    // ********************************************
    initial begin
        x = $urandom(18374);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (tab[i]) begin
            @(posedge clk);
            x = $urandom;
            a <= x;
            b <= (i % 3 == 0) ? x : $urandom;
            run(tab[i]);
            w = want(tab[i][39:32], tab[i][23:16]);
            if (w[32]) check(res, w[31:0]);
            if (w[32]) check(fl[3], w[31:0] == 32'h0);
            if (tab[i][7:0] == 8'h3b) check({fl[5], fl[0]}, 0);
            if (tab[i][39:24] == 16'h0fc1) check(res, a + b);
            if (tab[i][39:24] == 16'h0fc1) check(swp, a);
        end
        run(40'h8700000200);
        check(lk, 1);
        run(40'h0f78001400);
        check(ncs, 1);
        @(posedge clk);
        hold <= 4'h6;
        @(posedge clk);
        hold <= 4'h0;
        run(40'h9b00000000);
        check(k >= 4 && k <= 8, 1);
        @(posedge clk);
        wb <= 1'b1;
        dirty <= {12'h0, x[3:0]};
        run({24'h0f09c0, 8'(23 + x[3:0]), 8'h00});
        check(fs, 1);
        @(posedge clk);
        {real_m, wb, ea, sz} <= {2'b10, 32'hfffe, 3'h2};
        run(40'h290000013f);
        fault(24'h0f00e0, 8'h06);
        @(posedge clk);
        sz <= 3'h4;
        fault(24'h290000, 8'h0d);
        @(posedge clk);
        stk <= 1'b1;
        fault(24'h290000, 8'h0c);
        @(posedge clk);
        {real_m, smi} <= 2'b00;
        fault(24'h0f7a00, 8'h06);
        take(24'hd70000);
        check({pv, p0}, 9'h1d7);
        tally_and_finish();
    end

    // hang guard, far beyond the expected run length
    initial begin
        #(100 * 5000);
        mismatches++;
        tally_and_finish();
    end
endmodule : core_opcode_decode_tail_test
